// ==== design/tcm_pkg.sv ====
// ---------------------------------------------------------------------------
// shared constants and carriers for the timer capture / irq mask block
// ---------------------------------------------------------------------------
package tcm_pkg;

  // -------------------------------------------------------------------------
  // apb register map (byte addresses, one aligned word each)
  // -------------------------------------------------------------------------
  localparam int unsigned TCM_ADDR_W = 8;
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_MASK = 8'h00;  // timer_irq_mask
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_EMASK = 8'h04; // extended_timer_irq_mask
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_FLAGS = 8'h08; // timer_irq_flags
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_EFLAGS = 8'h0c; // extended_timer_irq_flags
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_CAP1_LO = 8'h10; // capture_value_t1 low byte
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_CAP1_HI = 8'h14; // capture_value_t1 high byte
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_CAP3_LO = 8'h18; // capture_value_t3 low byte
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_CAP3_HI = 8'h1c; // capture_value_t3 high byte
  localparam logic [TCM_ADDR_W-1:0] TCM_OFS_CTRL = 8'h20;  // capture control

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  localparam int unsigned TCM_BIT_CAP = 5;  // capture enable / flag
  localparam int unsigned TCM_BIT_CMPA = 4; // compare a
  localparam int unsigned TCM_BIT_CMPB = 3; // compare b
  localparam int unsigned TCM_BIT_OVF = 2;  // overflow
  localparam int unsigned TCM_BIT_X3C = 1;  // second timer compare c (extended)
  localparam int unsigned TCM_BIT_X1C = 0;  // first timer compare c (extended)
  localparam int unsigned TCM_FLAG_LO = 2;  // lowest first-timer bit in main flags
  localparam int unsigned TCM_EMASK_W = 6;  // implemented extended mask bits
  localparam int unsigned TCM_CTRL_W = 3;
  localparam int unsigned TCM_CTRL_RISE1 = 0; // first timer rising edge select
  localparam int unsigned TCM_CTRL_RISE3 = 1; // second timer rising edge select
  localparam int unsigned TCM_CTRL_ACMP1 = 2; // first timer uses comparator output

  // -------------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------------
  localparam logic [7:0] TCM_RST_MASK = 8'h00;
  localparam logic [TCM_EMASK_W-1:0] TCM_RST_EMASK = 6'h00;
  localparam logic [3:0] TCM_RST_FLAGS = 4'h0;
  localparam logic [TCM_EMASK_W-1:0] TCM_RST_EFLAGS = 6'h00;
  localparam logic [TCM_CTRL_W-1:0] TCM_RST_CTRL = 3'h0;
  localparam logic [15:0] TCM_RST_CAP = 16'h0000;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [TCM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } tcm_apb_req_type;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } tcm_apb_rsp_type;

  // what one 16-bit counter unit reports to this block
  typedef struct packed {
    logic [15:0] counter_value;
    logic capture_input_pin;
    logic top_is_capture; // waveform mode uses capture register as top
    logic top_reached;
    logic cmp_a_match;
    logic cmp_b_match;
    logic cmp_c_match;
    logic force_a;
    logic force_b;
    logic force_c;
    logic overflow;
  } tcm_timer_in_type;

  // one bit per interrupt source, used for requests and vector acks
  typedef struct packed {
    logic t1_capture;
    logic t1_cmp_a;
    logic t1_cmp_b;
    logic t1_overflow;
    logic t1_cmp_c;
    logic t3_capture;
    logic t3_cmp_a;
    logic t3_cmp_b;
    logic t3_overflow;
    logic t3_cmp_c;
  } tcm_irq_type;

  // whole register state of the top module
  typedef struct packed {
    logic [7:0] mask;
    logic [TCM_EMASK_W-1:0] emask;
    logic [3:0] flags;
    logic [TCM_EMASK_W-1:0] eflags;
    logic [7:0] temp;
    logic [TCM_CTRL_W-1:0] ctrl;
    logic ack;
    logic [31:0] prdata;
    logic slverr;
  } tcm_state_type;

  // state of one capture unit
  typedef struct packed {
    logic src_prev;
    logic [15:0] value;
  } tcm_cap_state_type;

endpackage

// ==== design/tcm_capture.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// one input capture register with edge select and source select
// ---------------------------------------------------------------------------
module tcm_capture
  import tcm_pkg::*;
#(
  parameter int unsigned WIDTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,            // capture input pin level
  input wire logic alt_i,            // alternative source level
  input wire logic alt_sel_i,        // use alternative source
  input wire logic rising_i,         // 1: rising edge, 0: falling edge
  input wire logic top_mode_i,       // register is the counter top
  input wire logic top_reached_i,    // counter hit top
  input wire logic [WIDTH-1:0] counter_i,
  input wire logic wr_i,             // software write strobe
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic [WIDTH-1:0] value_o,  // registered capture value
  output logic event_o               // flag set pulse
);

  tcm_cap_state_type q; // registered state
  tcm_cap_state_type d; // next state
  logic src;            // selected source level
  logic edge_hit;       // qualifying edge seen

  // -------------------------------------------------------------------------
  // edge detect and capture
  // -------------------------------------------------------------------------
  always_comb begin
    d = q;
    src = alt_sel_i ? alt_i : pin_i; // [RL2]
    edge_hit = rising_i ? (src & ~q.src_prev) : (~src & q.src_prev);
    d.src_prev = src;
    // in top mode the pin is cut off and the flag follows top instead
    event_o = top_mode_i ? top_reached_i : edge_hit;
    if (!top_mode_i && edge_hit) begin
      d.value = counter_i[WIDTH-1:0]; // [RL1]
    end else if (wr_i) begin
      // software writes only land when no capture competes
      d.value = wr_data_i;
    end
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{src_prev: 1'b0, value: TCM_RST_CAP};
    end else begin
      q <= d;
    end
  end

  assign value_o = q.value; // also the top value when selected [RL3]

endmodule // tcm_capture

// ==== design/tcm_irq_capture.sv ====
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
// Function
// RL1: capture pin event copies counter into register
// RL2: first timer may capture on comparator output
// RL3: capture register can serve as counter top
// RL4: low-byte read latches high byte into temp
// RL5: one temp register shared by all
// RL6: t1 capture request: mask5, global, flag
// RL7: t1 compare-a request: mask4, global, flag
// RL8: t1 compare-b request: mask3, global, flag
// RL9: t1 overflow request: mask2, global, flag
// RL10: t3 capture request: emask5, global, flag
// RL11: t3 compare-a request: emask4, global, flag
// RL12: t3 compare-b request: emask3, global, flag
// RL13: t3 overflow request: emask2, global, flag
// RL14: t3 compare-c request: emask1, global, flag
// RL15: t1 compare-c request: emask0, global, flag
// RL16: software writes zero to emask bits 7:6
// RL17: extended mask absent in legacy mode
// RL18: main flags: capture5, cmpa4, cmpb3, overflow2
// RL19: flags clear on vector or write-one
// RL20: compare flag set after match, not forced
// RL21: extended flags: t3 bits 5..1, t1c bit0
// RL22: requests are levels while all set
module tcm_irq_capture
  import tcm_pkg::*;
#(
  parameter int unsigned CAP_W = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire tcm_apb_req_type apb_i,
  output tcm_apb_rsp_type apb_o,
  input wire tcm_timer_in_type t1_i,
  input wire tcm_timer_in_type t3_i,
  input wire logic acomp_i,
  input wire logic global_irq_en_i,
  input wire logic legacy_mode_i,
  input wire tcm_irq_type irq_ack_i,
  output tcm_irq_type irq_req_o,
  output logic [CAP_W-1:0] capture_top_t1_o,
  output logic [CAP_W-1:0] capture_top_t3_o
);

  // -------------------------------------------------------------------------
  // local declarations
  // -------------------------------------------------------------------------
  localparam int unsigned NTMR = 2;   // two 16-bit timers
  tcm_state_type q;                   // registered state
  tcm_state_type d;                   // next state
  tcm_timer_in_type tmr [NTMR];       // timer inputs by index
  logic [CAP_W-1:0] cap_val [NTMR];   // capture register contents
  logic [NTMR-1:0] cap_evt;           // capture flag set pulses
  logic [NTMR-1:0] cap_wr;            // capture write strobes
  logic [NTMR-1:0] rise_sel;          // per timer edge select
  logic [NTMR-1:0] alt_sel;           // per timer source select
  logic [NTMR-1:0] alt_src;           // per timer alternative source
  logic [CAP_W-1:0] cap_wdata;        // temp plus written low byte
  logic access;                       // apb access phase
  logic mapped;                       // address decodes to a register
  logic [3:0] flag_set;               // main flag set events
  logic [3:0] flag_clr;               // main flag clear events
  logic [TCM_EMASK_W-1:0] eflag_set;  // extended flag set events
  logic [TCM_EMASK_W-1:0] eflag_clr;  // extended flag clear events
  logic [TCM_EMASK_W-1:0] emask_eff;  // extended mask as seen by logic
  logic [31:0] rd_word;               // read mux result

  // -------------------------------------------------------------------------
  // address decode helpers
  // -------------------------------------------------------------------------
  // word match, low two address bits ignored as for any aligned word
  function automatic logic hit(input logic [TCM_ADDR_W-1:0] a, input logic [TCM_ADDR_W-1:0] ofs);
    hit = (a[TCM_ADDR_W-1:2] == ofs[TCM_ADDR_W-1:2]);
  endfunction

  // true when the address names any implemented register
  function automatic logic is_mapped(input logic [TCM_ADDR_W-1:0] a);
    is_mapped = hit(a, TCM_OFS_MASK) | hit(a, TCM_OFS_EMASK) | hit(a, TCM_OFS_FLAGS)
      | hit(a, TCM_OFS_EFLAGS) | hit(a, TCM_OFS_CAP1_LO) | hit(a, TCM_OFS_CAP1_HI)
      | hit(a, TCM_OFS_CAP3_LO) | hit(a, TCM_OFS_CAP3_HI) | hit(a, TCM_OFS_CTRL);
  endfunction

  // place a 4-bit first-timer flag group at its bit positions
  function automatic logic [7:0] main_flags_byte(input logic [3:0] f);
    main_flags_byte = {2'b00, f, 2'b00};
  endfunction

  // -------------------------------------------------------------------------
  // capture units, one per timer
  // -------------------------------------------------------------------------
  assign tmr[0] = t1_i;
  assign tmr[1] = t3_i;
  assign rise_sel = {q.ctrl[TCM_CTRL_RISE3], q.ctrl[TCM_CTRL_RISE1]};
  // only the first timer has the comparator as an alternative source
  assign alt_sel = {1'b0, q.ctrl[TCM_CTRL_ACMP1]}; // [RL2]
  assign alt_src = {1'b0, acomp_i};

  generate
    for (genvar i = 0; i < NTMR; i++) begin : g_cap
      tcm_capture #(
        .WIDTH(CAP_W)
      ) u_cap (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pin_i(tmr[i].capture_input_pin),
        .alt_i(alt_src[i]),
        .alt_sel_i(alt_sel[i]),
        .rising_i(rise_sel[i]),
        .top_mode_i(tmr[i].top_is_capture),
        .top_reached_i(tmr[i].top_reached),
        .counter_i(tmr[i].counter_value),
        .wr_i(cap_wr[i]),
        .wr_data_i(cap_wdata),
        .value_o(cap_val[i]),
        .event_o(cap_evt[i])
      );
    end
  endgenerate

  // capture contents double as top for the counter units
  assign capture_top_t1_o = cap_val[0]; // [RL3]
  assign capture_top_t3_o = cap_val[1]; // [RL3]

  // -------------------------------------------------------------------------
  // hardware flag set events
  // -------------------------------------------------------------------------
  // compare inputs arrive on the match cycle; the flag register makes the
  // flag visible one clock later, and a forced compare never counts
  always_comb begin
    flag_set = '0;
    flag_set[TCM_BIT_CAP - TCM_FLAG_LO] = cap_evt[0];
    flag_set[TCM_BIT_CMPA - TCM_FLAG_LO] = t1_i.cmp_a_match & ~t1_i.force_a; // [RL20]
    flag_set[TCM_BIT_CMPB - TCM_FLAG_LO] = t1_i.cmp_b_match & ~t1_i.force_b; // [RL20]
    flag_set[TCM_BIT_OVF - TCM_FLAG_LO] = t1_i.overflow;
    eflag_set = '0;
    eflag_set[TCM_BIT_CAP] = cap_evt[1];
    eflag_set[TCM_BIT_CMPA] = t3_i.cmp_a_match & ~t3_i.force_a; // [RL20]
    eflag_set[TCM_BIT_CMPB] = t3_i.cmp_b_match & ~t3_i.force_b; // [RL20]
    eflag_set[TCM_BIT_OVF] = t3_i.overflow;
    eflag_set[TCM_BIT_X3C] = t3_i.cmp_c_match & ~t3_i.force_c; // [RL20]
    eflag_set[TCM_BIT_X1C] = t1_i.cmp_c_match & ~t1_i.force_c; // [RL20]
  end

  // -------------------------------------------------------------------------
  // read mux
  // -------------------------------------------------------------------------
  always_comb begin
    rd_word = '0;
    if (hit(apb_i.paddr, TCM_OFS_MASK)) begin
      rd_word[7:0] = q.mask;
    end else if (hit(apb_i.paddr, TCM_OFS_EMASK)) begin
      // absent in legacy mode, reserved top bits read zero
      rd_word[TCM_EMASK_W-1:0] = emask_eff; // [RL17]
    end else if (hit(apb_i.paddr, TCM_OFS_FLAGS)) begin
      rd_word[7:0] = main_flags_byte(q.flags); // [RL18]
    end else if (hit(apb_i.paddr, TCM_OFS_EFLAGS)) begin
      rd_word[TCM_EMASK_W-1:0] = q.eflags; // [RL21]
    end else if (hit(apb_i.paddr, TCM_OFS_CAP1_LO)) begin
      rd_word[7:0] = cap_val[0][7:0];
    end else if (hit(apb_i.paddr, TCM_OFS_CAP3_LO)) begin
      rd_word[7:0] = cap_val[1][7:0];
    end else if (hit(apb_i.paddr, TCM_OFS_CAP1_HI) || hit(apb_i.paddr, TCM_OFS_CAP3_HI)) begin
      // high byte always comes from the shared temp [RL4]
      rd_word[7:0] = q.temp;
    end else if (hit(apb_i.paddr, TCM_OFS_CTRL)) begin
      rd_word[TCM_CTRL_W-1:0] = q.ctrl;
    end else begin
      rd_word = '0; // unmapped reads zero and errors
    end
  end

  // -------------------------------------------------------------------------
  // next state: apb slave, flags, temp
  // -------------------------------------------------------------------------
  // one wait state: the first access cycle snapshots read data (and the
  // temp byte) so a flag set mid-transfer cannot tear the answer; writes
  // land on the completing edge where pready is high
  always_comb begin
    d = q;
    access = apb_i.psel & apb_i.penable;
    mapped = is_mapped(apb_i.paddr);
    cap_wr = '0;
    cap_wdata = {q.temp, apb_i.pwdata[7:0]};
    flag_clr = '0;
    eflag_clr = '0;
    if (access && !q.ack) begin
      // first access cycle: snapshot the answer
      d.ack = 1'b1;
      d.prdata = rd_word;
      d.slverr = ~mapped;
      if (!apb_i.pwrite && hit(apb_i.paddr, TCM_OFS_CAP1_LO)) begin
        d.temp = cap_val[0][CAP_W-1:8]; // [RL4] [RL5]
      end else if (!apb_i.pwrite && hit(apb_i.paddr, TCM_OFS_CAP3_LO)) begin
        d.temp = cap_val[1][CAP_W-1:8]; // [RL4] [RL5]
      end
    end else if (access && q.ack) begin
      // completing edge: commit writes
      d.ack = 1'b0;
      if (apb_i.pwrite && mapped) begin
        if (hit(apb_i.paddr, TCM_OFS_MASK)) begin
          d.mask = apb_i.pwdata[7:0];
        end else if (hit(apb_i.paddr, TCM_OFS_EMASK)) begin
          // reserved bits are not stored, so a stray one is harmless [RL16]
          if (!legacy_mode_i) begin
            d.emask = apb_i.pwdata[TCM_EMASK_W-1:0]; // [RL17]
          end
        end else if (hit(apb_i.paddr, TCM_OFS_FLAGS)) begin
          flag_clr = apb_i.pwdata[TCM_BIT_CAP:TCM_FLAG_LO]; // [RL19]
        end else if (hit(apb_i.paddr, TCM_OFS_EFLAGS)) begin
          eflag_clr = apb_i.pwdata[TCM_EMASK_W-1:0]; // [RL19]
        end else if (hit(apb_i.paddr, TCM_OFS_CAP1_HI) || hit(apb_i.paddr, TCM_OFS_CAP3_HI)) begin
          // high byte waits in the shared temp for the low byte [RL5]
          d.temp = apb_i.pwdata[7:0];
        end else if (hit(apb_i.paddr, TCM_OFS_CAP1_LO)) begin
          cap_wr[0] = 1'b1; // temp and low byte land together
        end else if (hit(apb_i.paddr, TCM_OFS_CAP3_LO)) begin
          cap_wr[1] = 1'b1;
        end else if (hit(apb_i.paddr, TCM_OFS_CTRL)) begin
          d.ctrl = apb_i.pwdata[TCM_CTRL_W-1:0];
        end
      end
    end else begin
      d.ack = 1'b0; // idle or setup cycle
    end
    // vector execution clears its own flag [RL19]
    flag_clr[TCM_BIT_CAP - TCM_FLAG_LO] |= irq_ack_i.t1_capture;
    flag_clr[TCM_BIT_CMPA - TCM_FLAG_LO] |= irq_ack_i.t1_cmp_a;
    flag_clr[TCM_BIT_CMPB - TCM_FLAG_LO] |= irq_ack_i.t1_cmp_b;
    flag_clr[TCM_BIT_OVF - TCM_FLAG_LO] |= irq_ack_i.t1_overflow;
    eflag_clr[TCM_BIT_CAP] |= irq_ack_i.t3_capture;
    eflag_clr[TCM_BIT_CMPA] |= irq_ack_i.t3_cmp_a;
    eflag_clr[TCM_BIT_CMPB] |= irq_ack_i.t3_cmp_b;
    eflag_clr[TCM_BIT_OVF] |= irq_ack_i.t3_overflow;
    eflag_clr[TCM_BIT_X3C] |= irq_ack_i.t3_cmp_c;
    eflag_clr[TCM_BIT_X1C] |= irq_ack_i.t1_cmp_c;
    // a set in the clearing cycle wins, so no event is lost
    d.flags = (q.flags & ~flag_clr) | flag_set; // [RL18] [RL19]
    d.eflags = (q.eflags & ~eflag_clr) | eflag_set; // [RL21] [RL19]
  end

  // -------------------------------------------------------------------------
  // state register
  // -------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '{
        mask: TCM_RST_MASK,
        emask: TCM_RST_EMASK,
        flags: TCM_RST_FLAGS,
        eflags: TCM_RST_EFLAGS,
        temp: 8'h00,
        ctrl: TCM_RST_CTRL,
        ack: 1'b0,
        prdata: 32'h0000_0000,
        slverr: 1'b0
      };
    end else begin
      q <= d;
    end
  end

  // -------------------------------------------------------------------------
  // apb answer
  // -------------------------------------------------------------------------
  // pready is a handshake term, data and error come from flops
  assign apb_o.pready = apb_i.psel & apb_i.penable & q.ack;
  assign apb_o.prdata = q.prdata;
  assign apb_o.pslverr = q.slverr & apb_o.pready;

  // -------------------------------------------------------------------------
  // interrupt requests
  // -------------------------------------------------------------------------
  // legacy mode removes the extended mask, so its sources stay quiet
  assign emask_eff = legacy_mode_i ? '0 : q.emask; // [RL17]

  // plain and of enable, flag and global enable: a level, not a pulse;
  // it drops as soon as the flag is cleared by vector or software
  always_comb begin
    irq_req_o.t1_capture = global_irq_en_i & q.mask[TCM_BIT_CAP]
      & q.flags[TCM_BIT_CAP - TCM_FLAG_LO]; // [RL6] [RL22]
    irq_req_o.t1_cmp_a = global_irq_en_i & q.mask[TCM_BIT_CMPA]
      & q.flags[TCM_BIT_CMPA - TCM_FLAG_LO]; // [RL7] [RL22]
    irq_req_o.t1_cmp_b = global_irq_en_i & q.mask[TCM_BIT_CMPB]
      & q.flags[TCM_BIT_CMPB - TCM_FLAG_LO]; // [RL8] [RL22]
    irq_req_o.t1_overflow = global_irq_en_i & q.mask[TCM_BIT_OVF]
      & q.flags[TCM_BIT_OVF - TCM_FLAG_LO]; // [RL9] [RL22]
    irq_req_o.t3_capture = global_irq_en_i & emask_eff[TCM_BIT_CAP]
      & q.eflags[TCM_BIT_CAP]; // [RL10] [RL22]
    irq_req_o.t3_cmp_a = global_irq_en_i & emask_eff[TCM_BIT_CMPA]
      & q.eflags[TCM_BIT_CMPA]; // [RL11] [RL22]
    irq_req_o.t3_cmp_b = global_irq_en_i & emask_eff[TCM_BIT_CMPB]
      & q.eflags[TCM_BIT_CMPB]; // [RL12] [RL22]
    irq_req_o.t3_overflow = global_irq_en_i & emask_eff[TCM_BIT_OVF]
      & q.eflags[TCM_BIT_OVF]; // [RL13] [RL22]
    irq_req_o.t3_cmp_c = global_irq_en_i & emask_eff[TCM_BIT_X3C]
      & q.eflags[TCM_BIT_X3C]; // [RL14] [RL22]
    irq_req_o.t1_cmp_c = global_irq_en_i & emask_eff[TCM_BIT_X1C]
      & q.eflags[TCM_BIT_X1C]; // [RL15] [RL22]
  end

endmodule // tcm_irq_capture

// ==== tb/tcm_irq_capture_monitor.sv ====
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// port-level checks for the capture / irq block
// ---------------------------------------------------------------------------
module tcm_irq_capture_monitor
  import tcm_pkg::*;
#(
  parameter int unsigned CAP_W = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire tcm_apb_req_type apb_i,
  input wire tcm_apb_rsp_type apb_o,
  input wire tcm_timer_in_type t1_i,
  input wire tcm_timer_in_type t3_i,
  input wire logic acomp_i,
  input wire logic global_irq_en_i,
  input wire logic legacy_mode_i,
  input wire tcm_irq_type irq_ack_i,
  input wire tcm_irq_type irq_req_o,
  input wire logic [CAP_W-1:0] capture_top_t1_o,
  input wire logic [CAP_W-1:0] capture_top_t3_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  property p_gie; !global_irq_en_i |-> irq_req_o == '0; endproperty
  a_gie: assert property (p_gie) else $error("request without global enable");
  property p_legacy; legacy_mode_i [*2] |-> irq_req_o[5:0] == 6'h00; endproperty
  a_legacy: assert property (p_legacy) else $error("extended request in legacy mode");
  property p_force; $rose(irq_req_o.t1_cmp_a) && $past(global_irq_en_i) && !$past(apb_o.pready)
    |-> $past(t1_i.cmp_a_match && !t1_i.force_a); endproperty
  a_force: assert property (p_force) else $error("compare flag without real match");
  property p_cap1; $changed(capture_top_t1_o) && !$past(apb_o.pready)
    |-> !$past(t1_i.top_is_capture) && capture_top_t1_o == $past(t1_i.counter_value); endproperty
  a_cap1: assert property (p_cap1) else $error("t1 capture value wrong");
  property p_cap3; $changed(capture_top_t3_o) && !$past(apb_o.pready)
    |-> capture_top_t3_o == $past(t3_i.counter_value); endproperty
  a_cap3: assert property (p_cap3) else $error("t3 capture value wrong");
  property p_ack; irq_ack_i.t1_capture && $stable(t1_i.capture_input_pin) && $stable(acomp_i)
    && !t1_i.top_reached |=> !irq_req_o.t1_capture; endproperty
  a_ack: assert property (p_ack) else $error("vector did not clear capture flag");
  property p_ack3; irq_ack_i.t3_cmp_c && !t3_i.cmp_c_match |-> ##1 irq_req_o.t3_cmp_c == 1'b0; endproperty
  a_ack3: assert property (p_ack3) else $error("vector did not clear t3 compare c");
  property p_hold; irq_req_o.t1_capture && !irq_ack_i.t1_capture && !apb_o.pready ##1 global_irq_en_i
    |-> irq_req_o.t1_capture; endproperty
  a_hold: assert property (p_hold) else $error("request level dropped");
  cover property ($changed(capture_top_t1_o));
  cover property (irq_ack_i != '0);
  cover property (apb_o.pready && apb_o.pslverr);
endmodule // tcm_irq_capture_monitor

// ==== tb/tcm_cpu_model.sv ====
`timescale 1ns/10ps
// core side: runs one vector at a time for the sources it is told to take
module tcm_cpu_model
  import tcm_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire tcm_irq_type irq_req_i,
  input wire tcm_irq_type take_i,
  output tcm_irq_type irq_ack_o
);
  wire [9:0] sel = irq_req_i & take_i; // pending and serviced
  // lowest pending bit wins, one-cycle ack, then a gap so a level is not acked twice
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ack_o <= '0;
    end else if (irq_ack_o != '0) begin
      irq_ack_o <= '0;
    end else begin
      irq_ack_o <= sel & ~(sel - 10'h1);
    end
  end
endmodule // tcm_cpu_model

// ==== tb/tcm_irq_capture_tb_top.sv ====
`timescale 1ns/10ps
module tcm_irq_capture_tb_top;
  import tcm_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic acomp_i = 1'b0;
  logic gie = 1'b0;
  logic legacy = 1'b0;
  tcm_apb_req_type apb_i = '0;
  tcm_apb_rsp_type apb_o;
  tcm_timer_in_type t1_i = {16'ha5c3, 10'h200}; // pin idles high
  tcm_timer_in_type t3_i = {16'h5a3c, 10'h200};
  tcm_irq_type req, ack;
  tcm_irq_type take = '0;
  logic [15:0] cap1, cap3;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int bp[11] = '{5, 4, 3, 2, 0, 5, 4, 3, 2, 1, 5}; // flag bit of each source
  logic [7:0] ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20};
  always #50 clk_i = ~clk_i;
  tcm_irq_capture #(.CAP_W(16)) uut (.clk_i(clk_i), .nrst_i(nrst_i), .apb_i(apb_i), .apb_o(apb_o),
    .t1_i(t1_i), .t3_i(t3_i), .acomp_i(acomp_i), .global_irq_en_i(gie), .legacy_mode_i(legacy),
    .irq_ack_i(ack), .irq_req_o(req), .capture_top_t1_o(cap1), .capture_top_t3_o(cap3));
  tcm_cpu_model cpu (.clk_i(clk_i), .nrst_i(nrst_i), .irq_req_i(req), .take_i(take), .irq_ack_o(ack));
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after an edge; ends one idle edge later
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] q);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    do @(posedge clk_i); while (apb_o.pready !== 1'b1);
    q = {apb_o.pslverr, apb_o.prdata};
    apb_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // one event pulse; returns one edge after the edge at which the flag becomes visible
  task automatic ev(input int i, input logic f);
    case (i)
      0: t1_i.capture_input_pin <= 1'b0;
      1: t1_i.cmp_a_match <= 1'b1;
      2: t1_i.cmp_b_match <= 1'b1;
      3: t1_i.overflow <= 1'b1;
      4: t1_i.cmp_c_match <= 1'b1;
      5: t3_i.capture_input_pin <= 1'b0;
      6: t3_i.cmp_a_match <= 1'b1;
      7: t3_i.cmp_b_match <= 1'b1;
      8: t3_i.overflow <= 1'b1;
      9: t3_i.cmp_c_match <= 1'b1;
      default: t1_i.top_reached <= 1'b1;
    endcase
    t1_i.force_a <= f;
    @(posedge clk_i);
    t1_i <= {t1_i.counter_value, 1'b1, t1_i.top_is_capture, 8'h00};
    t3_i <= {t3_i.counter_value, 10'h200};
    @(posedge clk_i);
  endtask
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    foreach (ra[k]) rd(ra[k], 33'h0);
    rd(8'h24, 33'h1_0000_0000);
    wr(8'h00, 32'hff);
    rd(8'h00, 33'hff);
    wr(8'h04, 32'h3f);
    rd(8'h04, 33'h3f);
    gie <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      ev(i, 1'b0);
      chk(req, 10'h200 >> i);
      rd(i < 4 ? 8'h08 : 8'h0c, 33'h1 << bp[i]);
      wr(i < 4 ? 8'h08 : 8'h0c, 32'h1 << bp[i]);
      chk(req, 0);
    end
    rd(8'h10, 33'hc3);
    t1_i.counter_value <= 16'h7e81;
    ev(0, 1'b0);
    rd(8'h14, 33'ha5);
    rd(8'h10, 33'h81);
    rd(8'h1c, 33'h7e);
    rd(8'h18, 33'h3c);
    rd(8'h1c, 33'h5a);
    ev(1, 1'b1);
    chk(req, 10'h200);
    gie <= 1'b0;
    ev(9, 1'b0);
    chk(req, 0);
    gie <= 1'b1;
    take <= 10'h3ff;
    repeat (6) @(posedge clk_i);
    chk(req, 0);
    take <= 10'h000;
    t1_i.top_is_capture <= 1'b1;
    t1_i.counter_value <= 16'h0f0f;
    ev(0, 1'b0);
    chk(req, 0);
    ev(10, 1'b0);
    chk(req, 10'h200);
    chk(cap1, 16'h7e81);
    t1_i.top_is_capture <= 1'b0;
    wr(8'h20, 32'h5);
    acomp_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(cap1, 16'h0f0f);
    wr(8'h1c, 32'h12);
    wr(8'h18, 32'h34);
    chk(cap3, 16'h1234);
    legacy <= 1'b1;
    ev(9, 1'b0);
    chk(req[5:0], 0);
    rd(8'h04, 33'h0);
    end_of_test();
  end
endmodule // tcm_irq_capture_tb_top
bind tcm_irq_capture tcm_irq_capture_monitor #(.CAP_W(CAP_W)) u_mon (.clk_i(clk_i), .nrst_i(nrst_i),
  .apb_i(apb_i), .apb_o(apb_o), .t1_i(t1_i), .t3_i(t3_i), .acomp_i(acomp_i),
  .global_irq_en_i(global_irq_en_i), .legacy_mode_i(legacy_mode_i), .irq_ack_i(irq_ack_i),
  .irq_req_o(irq_req_o), .capture_top_t1_o(capture_top_t1_o), .capture_top_t3_o(capture_top_t3_o));
